/* File: hdl/arfb_pkg.sv */
// What this block does
// - write while busy reports busy code
// - mode forbids operation reports wrong-mode code
// - running automatic tuning reports tuning code
// - temporarily unable reports unable code
// - error-changed flag added onto reported code
// - state nibble: 0,2,4,6 manual/auto, local/remote
// - data field carries item number then value
// - alarm digit bits: on1, change1, on2, change2
// - change flags catch transitions between polls
// - alarms three/four replace change bits when enabled
// - state change shows from next transaction on
// - checksum is two hex chars, carry-free sum
// - request status 00, 01, 02 or 04
`default_nettype none
package arfb_pkg;
  ////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
  // control and irq bit positions
  localparam int CTRL_ALM34   = 0;
  localparam int IRQ_DONE     = 1'h0;
  localparam int IRQ_ALARM    = 1'h1;
  localparam int IRQ_W        = 2;
  ////////////////////////////////////////////////////////////////////////
  // request status selector from the parser and its codes
  typedef enum logic [1:0] {
    REQ_OK, REQ_FORMAT, REQ_UNSUPPORTED, REQ_CHECKSUM
  } arfb_req_e;
  localparam logic [7:0] RS_OK          = 8'h00;
  localparam logic [7:0] RS_FORMAT      = 8'h01;
  localparam logic [7:0] RS_UNSUPPORTED = 8'h02;
  localparam logic [7:0] RS_CHECKSUM    = 8'h04;
  // controller status codes
  localparam logic [7:0] CS_OK      = 8'h00;
  localparam logic [7:0] CS_BUSY    = 8'hd2;
  localparam logic [7:0] CS_MODE    = 8'hd4;
  localparam logic [7:0] CS_TUNING  = 8'hd6;
  localparam logic [7:0] CS_UNABLE  = 8'hd7;
  localparam logic [7:0] CS_ERRCHG  = 8'hb0;
  ////////////////////////////////////////////////////////////////////////
  // ascii characters
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_ALPHA = 8'h37;  // 'A' minus ten
  localparam logic [3:0] HEAD_LAST = 4'hd;  // last head position
  // emission phases
  typedef enum logic [2:0] {
    PH_IDLE, PH_HEAD, PH_VALUE, PH_SUMSEP, PH_SUMHI, PH_SUMLO,
    PH_CR, PH_LF
  } arfb_phase_e;
endpackage
`default_nettype wire

/* File: hdl/arfb_response_builder.sv */
`timescale 1ns/1ps
`default_nettype none
module arfb_response_builder #(
  parameter int VALUE_CHARS = 8   // longest value text
) (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // ahb-lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic                            irq,
  // request from the parser
  input  wire logic                       reqValid,
  input  wire logic [1:0]                 reqResult,
  input  wire logic                       reqIsWrite,
  input  wire logic                       reqWithSum,
  input  wire logic [11:0]                reqItem,
  input  wire logic [8*VALUE_CHARS-1:0]   reqValue,
  input  wire logic [3:0]                 reqValueLen,
  output logic                            reqReady,
  // controller condition, same clock
  input  wire logic                       ctlBusy,
  input  wire logic                       ctlModeForbids,
  input  wire logic                       ctlTuning,
  input  wire logic                       ctlUnable,
  input  wire logic                       ctlErrorChanged,
  input  wire logic                       ctlAuto,
  input  wire logic                       ctlRemoteSetpoint,
  input  wire logic [3:0]                 alarmOn,
  // response character stream
  output logic      [7:0]                 txData,
  output logic                            txValid,
  input  wire logic                       txReady
);
  ////////////////////////////////////////////////////////////////////////
  // whole state of the block
  typedef struct packed {
    arfb_pkg::arfb_phase_e    phase;      // emission phase
    logic [3:0]               pos;        // head position
    logic [3:0]               vIdx;       // value character index
    logic [7:0]               sum;        // running checksum
    logic [7:0]               txData;     // character on the stream
    logic                     txValid;    // character offered
    logic [7:0]               reqCode;    // latched request status
    logic [7:0]               ctlCode;    // latched controller status
    logic [3:0]               stateNib;   // latched state and mode
    logic [3:0]               alarmNib;   // latched alarm digit
    logic [11:0]              item;       // latched item digits
    logic [8*VALUE_CHARS-1:0] value;      // latched value text
    logic [3:0]               vLen;       // latched value length
    logic                     withSum;    // latched protocol class
    logic [3:0]               shown;      // state and mode to report
    logic [1:0]               cos;        // alarm change flags
    logic [1:0]               prevOn;     // alarm one/two last level
    logic                     errSticky;  // error status changed
    logic                     alm34;      // alarms three/four mode
    logic [arfb_pkg::IRQ_W-1:0] irqStat;  // sticky events
    logic [arfb_pkg::IRQ_W-1:0] irqMask;  // event enables
    logic                     dSel;       // data phase pending
    logic                     dWrite;     // data phase is a write
    logic [7:0]               dAddr;      // data phase address
    logic [31:0]              hrdata;     // read data
    logic                     irq;        // interrupt line
    logic                     reqReady;   // idle, next request taken
  } arfb_state_s;

  arfb_state_s s;       // registered state
  arfb_state_s next_s;  // next state

  // ascii hex digit of a nibble
  function automatic logic [7:0] hexChar(input logic [3:0] n);
    hexChar = (n < 4'ha) ? arfb_pkg::CH_ZERO + {4'h0, n}
                         : arfb_pkg::CH_ALPHA + {4'h0, n};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // combinational next state
  logic [7:0] ch;        // character chosen this cycle
  logic       emit;      // stream slot is free
  logic       accept;    // request taken
  logic [7:0] code;      // controller status before the flag
  logic [1:0] edgeSeen;  // alarm one/two transition now
  logic [arfb_pkg::IRQ_W-1:0] w1c; // irq bits cleared by software
  logic [7:0] rsel;      // read address
  always_comb begin
    next_s   = s;
    ch       = arfb_pkg::CH_COMMA;
    w1c      = '0;
    rsel     = haddr[7:0];
    emit     = !s.txValid || txReady;
    accept   = reqValid && s.reqReady;  // a pending character may wait
    edgeSeen = alarmOn[1:0] ^ s.prevOn;
    next_s.prevOn = alarmOn[1:0];
    // controller status priority
    if (ctlUnable) begin
      code = arfb_pkg::CS_UNABLE;
    end else if (ctlTuning) begin
      code = arfb_pkg::CS_TUNING;
    end else if (ctlModeForbids) begin
      code = arfb_pkg::CS_MODE;
    end else if (ctlBusy && reqIsWrite) begin
      code = arfb_pkg::CS_BUSY;
    end else begin
      code = arfb_pkg::CS_OK;
    end
    // stream slot released
    if (s.txValid && txReady) begin
      next_s.txValid = 1'b0;
    end
    // change flags: a new edge wins over the clear at accept
    next_s.cos = (accept ? 2'b00 : s.cos) | edgeSeen;
    next_s.errSticky = (accept ? 1'b0 : s.errSticky) | ctlErrorChanged;
    // latch the fields of a new response
    if (accept) begin
      unique case (arfb_pkg::arfb_req_e'(reqResult))
        arfb_pkg::REQ_OK:          next_s.reqCode = arfb_pkg::RS_OK;
        arfb_pkg::REQ_FORMAT:      next_s.reqCode = arfb_pkg::RS_FORMAT;
        arfb_pkg::REQ_UNSUPPORTED: next_s.reqCode = arfb_pkg::RS_UNSUPPORTED;
        arfb_pkg::REQ_CHECKSUM:    next_s.reqCode = arfb_pkg::RS_CHECKSUM;
      endcase
      // error flag adds onto the code, carry dropped
      next_s.ctlCode = s.errSticky ?
          8'(code + arfb_pkg::CS_ERRCHG) : code;
      next_s.stateNib = s.shown;
      next_s.alarmNib = {s.alm34 ? alarmOn[3] : s.cos[1], alarmOn[1],
                         s.alm34 ? alarmOn[2] : s.cos[0],
                         alarmOn[0]};
      next_s.item    = reqItem;
      next_s.value   = reqValue;
      next_s.vLen    = (reqValueLen == 4'h0) ? 4'h1 : reqValueLen;
      next_s.withSum = reqWithSum;
      next_s.phase   = arfb_pkg::PH_HEAD;
      next_s.pos     = 4'h0;
      next_s.vIdx    = 4'h0;
      next_s.sum     = 8'h00;
    end else if (emit && s.phase != arfb_pkg::PH_IDLE) begin
      // emit one character of the response
      unique case (s.phase)
        arfb_pkg::PH_HEAD: begin
          unique case (s.pos)
            4'h0:    ch = hexChar(s.reqCode[7:4]);
            4'h1:    ch = hexChar(s.reqCode[3:0]);
            4'h3:    ch = hexChar(s.ctlCode[7:4]);
            4'h4:    ch = hexChar(s.ctlCode[3:0]);
            4'h6:    ch = hexChar(s.stateNib);
            4'h8:    ch = hexChar(s.alarmNib);
            4'ha:    ch = hexChar(s.item[11:8]);
            4'hb:    ch = hexChar(s.item[7:4]);
            4'hc:    ch = hexChar(s.item[3:0]);
            default: ch = arfb_pkg::CH_COMMA;
          endcase
          next_s.pos = s.pos + 4'h1;
          if (s.pos == arfb_pkg::HEAD_LAST) begin
            next_s.phase = arfb_pkg::PH_VALUE;
          end
        end
        arfb_pkg::PH_VALUE: begin
          ch = s.value[8*VALUE_CHARS-1 - 8*s.vIdx -: 8];
          next_s.vIdx = s.vIdx + 4'h1;
          if (s.vIdx + 4'h1 >= s.vLen) begin
            next_s.phase = s.withSum ? arfb_pkg::PH_SUMSEP
                                     : arfb_pkg::PH_CR;
          end
        end
        arfb_pkg::PH_SUMSEP: begin
          ch = arfb_pkg::CH_COMMA;
          next_s.phase = arfb_pkg::PH_SUMHI;
        end
        arfb_pkg::PH_SUMHI: begin
          ch = hexChar(s.sum[7:4]);
          next_s.phase = arfb_pkg::PH_SUMLO;
        end
        arfb_pkg::PH_SUMLO: begin
          ch = hexChar(s.sum[3:0]);
          next_s.phase = arfb_pkg::PH_CR;
        end
        arfb_pkg::PH_CR: begin
          ch = arfb_pkg::CH_CR;
          next_s.phase = arfb_pkg::PH_LF;
        end
        arfb_pkg::PH_LF: begin
          ch = arfb_pkg::CH_LF;
          next_s.phase = arfb_pkg::PH_IDLE;
          next_s.shown = {1'b0, ctlAuto, ctlRemoteSetpoint, 1'b0};
        end
        default: begin
          next_s.phase = arfb_pkg::PH_IDLE;
        end
      endcase
      next_s.txData  = ch;
      next_s.txValid = 1'b1;
      // carry-free sum of everything before the checksum
      if (s.phase == arfb_pkg::PH_HEAD || s.phase == arfb_pkg::PH_VALUE ||
          s.phase == arfb_pkg::PH_SUMSEP) begin
        next_s.sum = s.sum + ch;
      end
    end
    // ahb data phase: write
    if (s.dSel && s.dWrite) begin
      unique case (s.dAddr)
        arfb_pkg::OFF_CTRL:     next_s.alm34 = hwdata[arfb_pkg::CTRL_ALM34];
        arfb_pkg::OFF_IRQ_STAT: w1c = hwdata[arfb_pkg::IRQ_W-1:0];
        arfb_pkg::OFF_IRQ_MASK: next_s.irqMask = hwdata[arfb_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    // ahb address phase: capture and prepare read data
    next_s.dSel   = hsel && htrans[1] && hready;
    next_s.dWrite = hwrite;
    next_s.dAddr  = rsel;
    unique case (rsel)
      arfb_pkg::OFF_CTRL:     next_s.hrdata = {31'h0, s.alm34};
      arfb_pkg::OFF_STATUS:   next_s.hrdata = {27'h0, s.cos, s.errSticky,
                                 s.phase != arfb_pkg::PH_IDLE, s.txValid};
      arfb_pkg::OFF_IRQ_STAT: next_s.hrdata = {30'h0, s.irqStat};
      arfb_pkg::OFF_IRQ_MASK: next_s.hrdata = {30'h0, s.irqMask};
      default:                next_s.hrdata = 32'h0;
    endcase
    // sticky events, a new event wins over the clear
    next_s.irqStat = s.irqStat & ~w1c;
    next_s.irqStat[arfb_pkg::IRQ_DONE] |=
      emit && s.phase == arfb_pkg::PH_LF;
    next_s.irqStat[arfb_pkg::IRQ_ALARM] |= |edgeSeen;
    next_s.irq = |(next_s.irqStat & s.irqMask);
    // request ready kept in a flop, true whenever the phase is idle
    next_s.reqReady = (next_s.phase == arfb_pkg::PH_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.reqReady <= 1'b1;  // idle after reset
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flops, bus ready and response tied off
  assign hrdata    = s.hrdata;
  assign hreadyout = 1'b1;     // zero wait states
  assign hresp     = 1'b0;     // always okay
  assign irq       = s.irq;
  assign txData    = s.txData;
  assign txValid   = s.txValid;
  assign reqReady  = s.reqReady;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // accepted write while busy, nothing stronger present
  sequence accWrBusy;
    accept && ctlBusy && reqIsWrite && !ctlUnable && !ctlTuning &&
      !ctlModeForbids;
  endsequence

  // the same with no error change waiting
  sequence accWrBusyPlain;
    accWrBusy ##0 !s.errSticky;
  endsequence

  // the same with an error change waiting
  sequence accWrBusyErr;
    accWrBusy ##0 s.errSticky;
  endsequence

  // carriage return handed over to the host
  sequence crTaken;
    txValid && txReady && txData == arfb_pkg::CH_CR;
  endsequence

  // controller status codes and their priority
  a_busy_code: assert property (
      accWrBusyPlain |=> s.ctlCode == arfb_pkg::CS_BUSY)
    else $error("busy write not reported as busy");
  a_read_not_busy: assert property (
      accept && ctlBusy && !reqIsWrite && !ctlUnable && !ctlTuning &&
      !ctlModeForbids && !s.errSticky |=> s.ctlCode == arfb_pkg::CS_OK)
    else $error("busy reported for a read");
  a_mode_code: assert property (
      accept && ctlModeForbids && !ctlUnable && !ctlTuning &&
      !s.errSticky |=> s.ctlCode == arfb_pkg::CS_MODE)
    else $error("mode refusal code wrong");
  a_tune_code: assert property (
      accept && ctlTuning && !ctlUnable && !s.errSticky
      |=> s.ctlCode == arfb_pkg::CS_TUNING)
    else $error("tuning code wrong");
  a_unable_code: assert property (
      accept && ctlUnable && !s.errSticky
      |=> s.ctlCode == arfb_pkg::CS_UNABLE)
    else $error("unable code wrong");
  a_err_added: assert property (
      accWrBusyErr |=> s.ctlCode ==
      8'(arfb_pkg::CS_BUSY + arfb_pkg::CS_ERRCHG))
    else $error("error flag combined wrongly");

  // request status and request handshake
  a_req_code: assert property (
      accept && reqResult == arfb_pkg::REQ_CHECKSUM
      |=> s.reqCode == arfb_pkg::RS_CHECKSUM)
    else $error("checksum request status wrong");
  a_ready_idle: assert property (
      reqReady == (s.phase == arfb_pkg::PH_IDLE))
    else $error("request ready out of step with idle");

  // state and mode nibble
  a_state_code: assert property (
      emit && s.phase == arfb_pkg::PH_LF && ctlAuto && ctlRemoteSetpoint
      |=> s.shown == 4'h6)
    else $error("automatic remote state coded wrongly");
  a_state_late: assert property (
      accept |=> s.stateNib == $past(s.shown))
    else $error("state nibble not from last transaction");

  // alarm digit and change flags
  a_alarm_digit: assert property (
      accept && !s.alm34 && s.cos == 2'b11 && alarmOn[1:0] == 2'b10
      |=> s.alarmNib == 4'he)
    else $error("alarm digit bits wrong");
  a_alm34_digit: assert property (
      accept && s.alm34 && alarmOn == 4'hc |=> s.alarmNib == 4'ha)
    else $error("alarms three and four coded wrongly");
  a_cos_kept: assert property (
      $changed(alarmOn[0]) |=> s.cos[0])
    else $error("alarm one transition lost");
  a_cos_clear: assert property (
      accept && !(|edgeSeen) |=> s.cos == 2'b00)
    else $error("change flags not cleared");

  // data field, checksum and framing
  a_item_first: assert property (
      emit && s.phase == arfb_pkg::PH_HEAD && s.pos == 4'ha
      |=> txData == hexChar($past(s.item[11:8])))
    else $error("item number not first in data field");
  a_no_sum: assert property (
      s.phase == arfb_pkg::PH_VALUE && !s.withSum
      |=> s.phase != arfb_pkg::PH_SUMSEP)
    else $error("checksum sent without checksum class");
  a_sum_sent: assert property (
      emit && s.phase == arfb_pkg::PH_VALUE && s.withSum &&
      s.vIdx + 4'h1 >= s.vLen |=> s.phase == arfb_pkg::PH_SUMSEP)
    else $error("checksum missing for checksum class");
  a_lf_last: assert property (
      crTaken |=> txValid && txData == arfb_pkg::CH_LF)
    else $error("line feed does not follow carriage return");
endmodule // arfb_response_builder
`default_nettype wire

/* File: tb/arfb_host_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module arfb_host_sink (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // response character stream
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  output logic            txReady,
  // stall on alternate cycles when high
  input  wire logic       slow
);
  logic [7:0] q[$];  // characters received so far
  //////////////////////////////////////////////////////////////////////
  // take a char on each handshake, stall every other cycle if slow
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txReady <= 1'b0;
    end else begin
      if (txValid && txReady) q.push_back(txData);
      txReady <= slow ? ~txReady : 1'b1;
    end
  end
endmodule // arfb_host_sink
`default_nettype wire

/* File: tb/arfb_response_builder_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module arfb_response_builder_tb_top;
  logic        core_clk, rst, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, reqResult;
  logic [2:0]  hsize;
  logic        reqValid, reqIsWrite, reqWithSum, reqReady;
  logic [11:0] reqItem;
  logic [63:0] reqValue;
  logic [3:0]  reqValueLen, alarmOn;
  logic        ctlBusy, ctlModeForbids, ctlTuning, ctlUnable;
  logic        ctlErrorChanged, ctlAuto, ctlRemoteSetpoint;
  logic [7:0]  txData;
  logic        txValid, txReady, slow;
  int          n_mismatch, n_checks;
  // condition rows {unable,tuning,mode,busy,write} and their codes
  logic [4:0]  cnd [5] = '{5'h18, 5'h0c, 5'h07, 5'h02, 5'h03};
  logic [7:0]  cod [5] = '{8'hd7, 8'hd6, 8'hd4, 8'h00, 8'hd2};
  logic [7:0]  rsc [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
  logic [1:0]  stt [4] = '{2'h3, 2'h1, 2'h2, 2'h0};  // {auto,remote}
  logic [3:0]  prv;                                  // expected nibble
  assign hready = hreadyout;  // single slave drives the bus ready
  //////////////////////////////////////////////////////////////////////
  arfb_response_builder u_dut (.core_clk(core_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .reqValid(reqValid), .reqResult(reqResult), .reqIsWrite(reqIsWrite),
    .reqWithSum(reqWithSum), .reqItem(reqItem), .reqValue(reqValue),
    .reqValueLen(reqValueLen), .reqReady(reqReady), .ctlBusy(ctlBusy),
    .ctlModeForbids(ctlModeForbids), .ctlTuning(ctlTuning),
    .ctlUnable(ctlUnable), .ctlErrorChanged(ctlErrorChanged),
    .ctlAuto(ctlAuto), .ctlRemoteSetpoint(ctlRemoteSetpoint),
    .alarmOn(alarmOn), .txData(txData), .txValid(txValid),
    .txReady(txReady));
  arfb_host_sink sink (.core_clk(core_clk), .rst(rst), .txData(txData),
    .txValid(txValid), .txReady(txReady), .slow(slow));
  //////////////////////////////////////////////////////////////////////
  // clock generator
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // compare one value, count and report
  task automatic chk(input string what, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // one ahb-lite single word transfer, read data left in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // upper case hex digit
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction
  // expected response text from field values
  function automatic string mk(input logic [7:0] rs, cs,
                               input logic [3:0] st, al);
    string s;
    logic [7:0] sm;
    s = $sformatf("%c%c,%c%c,%c,%c,%c%c%c,12.5", hx(rs[7:4]), hx(rs[3:0]),
      hx(cs[7:4]), hx(cs[3:0]), hx(st), hx(al), hx(reqItem[11:8]),
      hx(reqItem[7:4]), hx(reqItem[3:0]));
    if (reqWithSum) begin
      s = {s, ","};
      sm = 8'h00;
      foreach (s[i]) sm += s[i];
      s = {s, $sformatf("%c%c", hx(sm[7:4]), hx(sm[3:0]))};
    end
    return {s, "\015\012"};
  endfunction
  // issue one request and compare the whole response
  task automatic send(input string e);
    int k;
    sink.q.delete();
    reqValid <= 1'b1;
    do @(posedge core_clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    k = 0;
    while (k < 300 && !(sink.q.size() > 0 && sink.q[$] === 8'h0a)) begin
      @(posedge core_clk);
      k++;
    end
    chk("length", e.len(), sink.q.size());
    for (int i = 0; i < e.len() && i < sink.q.size(); i++)
      chk("char", e[i], sink.q[i]);
    @(posedge core_clk);
  endtask
  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    end_of_test();
  end
  // main sequence
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, reqValid, reqResult} = '0;
    {reqIsWrite, reqWithSum, ctlBusy, ctlModeForbids, ctlTuning} = '0;
    {ctlUnable, ctlErrorChanged, ctlAuto, ctlRemoteSetpoint, slow} = '0;
    {alarmOn, n_mismatch, n_checks, prv} = '0;
    hsize = 3'h2;
    reqItem = 12'h125;
    reqValue = {"12.5", 32'h0};
    reqValueLen = 4'h4;
    rst = 1'b1;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("reqReady", 1, reqReady);
    ahb(1'b0, 8'h10, 0); chk("unmapped", 0, rd);
    // every request status, sink stalling
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      reqResult <= 2'(i);
      send(mk(rsc[i], 8'h00, 4'h0, 4'h0));
    end
    reqResult <= 2'h0;
    slow <= 1'b0;
    reqWithSum <= 1'b1;
    @(posedge core_clk);  // class settles before the text is built
    // controller status priority, checksum appended
    for (int i = 0; i < 5; i++) begin
      {ctlUnable, ctlTuning, ctlModeForbids, ctlBusy, reqIsWrite} <= cnd[i];
      send(mk(8'h00, cod[i], 4'h0, 4'h0));
    end
    // error change adds onto busy, then clears
    ctlErrorChanged <= 1'b1;
    @(posedge core_clk);
    ctlErrorChanged <= 1'b0;
    send(mk(8'h00, 8'h82, 4'h0, 4'h0));
    send(mk(8'h00, 8'hd2, 4'h0, 4'h0));
    {ctlBusy, reqIsWrite, reqWithSum} <= 3'h0;
    @(posedge core_clk);  // class settles before the text is built
    // state nibble lags by one transaction
    for (int i = 0; i < 4; i++) begin
      {ctlAuto, ctlRemoteSetpoint} <= stt[i];
      send(mk(8'h00, 8'h00, prv, 4'h0));
      prv = {1'b0, stt[i], 1'b0};
    end
    send(mk(8'h00, 8'h00, prv, 4'h0));
    // brief alarm one pulse and alarm two on between polls
    alarmOn[0] <= 1'b1;
    @(posedge core_clk);
    alarmOn[0] <= 1'b0;
    alarmOn[1] <= 1'b1;
    @(posedge core_clk);  // both transitions seen before the poll
    ahb(1'b0, 8'h04, 0); chk("status", 32'h18, rd);
    send(mk(8'h00, 8'h00, 4'h0, 4'he));
    send(mk(8'h00, 8'h00, 4'h0, 4'h4));
    // interrupts: masked, unmasked, cleared
    chk("irq masked", 0, irq);
    ahb(1'b0, 8'h08, 0); chk("irq stat", 3, rd);
    ahb(1'b1, 8'h0c, 3);
    repeat (2) @(posedge core_clk);
    chk("irq on", 1, irq);
    ahb(1'b1, 8'h08, 3);
    ahb(1'b0, 8'h08, 0); chk("irq clr", 0, rd);
    chk("irq off", 0, irq);
    // alarms three and four replace the change bits
    ahb(1'b1, 8'h00, 1);
    ahb(1'b0, 8'h00, 0); chk("ctrl", 1, rd);
    alarmOn <= 4'hc;
    send(mk(8'h00, 8'h00, 4'h0, 4'ha));
    alarmOn <= 4'h4;
    send(mk(8'h00, 8'h00, 4'h0, 4'h2));
    alarmOn <= 4'h8;
    send(mk(8'h00, 8'h00, 4'h0, 4'h8));
    end_of_test();
  end
endmodule // arfb_response_builder_tb_top
`default_nettype wire
